// >>> src/awm_pkg.sv
// awm_pkg: register map, reset values and codes of the window monitor
package awm_pkg;
	localparam int          AWM_NCH       = 3;
	localparam int          AWM_NTERM     = 6;
	localparam int          AWM_VW        = 8;
	localparam int          AWM_DW        = 11;
	// channel indices
	localparam int          AWM_CH_VOLT   = 0;
	localparam int          AWM_CH_CURR   = 1;
	localparam int          AWM_CH_BIP    = 2;
	// per channel block: base 0x10 * channel, word offsets inside it
	localparam logic [1:0]  AWM_R_UPPER   = 2'h0;
	localparam logic [1:0]  AWM_R_LOWER   = 2'h1;
	localparam logic [1:0]  AWM_R_HYST    = 2'h2;
	localparam logic [1:0]  AWM_R_SUBST   = 2'h3;
	localparam logic [7:0]  AWM_A_FLAGS   = 8'h30;
	localparam logic [7:0]  AWM_A_ISTAT   = 8'h34;
	localparam logic [7:0]  AWM_A_IMASK   = 8'h38;
	// terminal banks, word index = terminal
	localparam logic [2:0]  AWM_B_FSEL    = 3'h2;
	localparam logic [2:0]  AWM_B_ON      = 3'h3;
	localparam logic [2:0]  AWM_B_OFF     = 3'h4;
	// percent limits
	localparam logic signed [9:0] AWM_PCT_MAX  = 10'sd100;
	localparam logic signed [9:0] AWM_PCT_MIN  = -10'sd100;
	localparam logic signed [9:0] AWM_HYST_MAX = 10'sd10;
	localparam int          AWM_SUBST_IGN = 8;
	// reset values
	localparam logic [7:0]  AWM_RST_UPPER = 8'h64;
	localparam logic [7:0]  AWM_RST_LOWER = 8'h00;
	localparam logic [7:0]  AWM_RST_LOWBP = 8'h9C;
	localparam logic [7:0]  AWM_RST_HYST  = 8'h00;
	localparam logic [8:0]  AWM_RST_SUBST = 9'h100;
	localparam logic [7:0]  AWM_RST_FSEL  = 8'h00;
	// terminal function codes
	localparam logic [7:0]  AWM_F_DISC0   = 8'h1B;
	localparam logic [7:0]  AWM_F_DISC1   = 8'h1C;
	localparam logic [7:0]  AWM_F_DISC2   = 8'h1D;
	localparam logic [7:0]  AWM_F_WIN0    = 8'h36;
	localparam logic [7:0]  AWM_F_WIN1    = 8'h37;
	localparam logic [7:0]  AWM_F_WIN2    = 8'h38;
	// delays in tenths of a second
	localparam logic [10:0] AWM_DLY_MAX   = 11'h3E8;
	localparam int          AWM_CLK_HZ    = 20_000_000;
	localparam int          AWM_TICK_MS   = 100;
	localparam int          AWM_TICK_CYC  = AWM_TICK_MS * (AWM_CLK_HZ / 1000);
	// interrupt status layout
	localparam int          AWM_IRQ_W     = 4;
	localparam int          AWM_IRQ_REJ   = 3;
endpackage

// >>> src/awm_top.sv
// awm_top: three-channel window monitor with delayed output terminals
`timescale 1ns/1ps
`default_nettype none
module awm_top #(
	parameter int TICK_CYC = awm_pkg::AWM_TICK_CYC
) (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           resetn_i,
	// wishbone slave
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [7:0]                     wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [31:0]                    wb_dat_i,
	output logic [31:0]                         wb_dat_o,
	output logic                                wb_ack_o,
	// analog samples, signed percent
	input  wire logic [awm_pkg::AWM_VW-1:0]     chan_data_i [awm_pkg::AWM_NCH],
	output logic [awm_pkg::AWM_VW-1:0]          chan_data_o [awm_pkg::AWM_NCH],
	// flags
	output logic [awm_pkg::AWM_NCH-1:0]         window_flag_o,
	output logic [awm_pkg::AWM_NCH-1:0]         disconnect_o,
	// terminals 11..15 then alarm relay
	output logic [awm_pkg::AWM_NTERM-1:0]       term_o,
	output logic                                irq_o
);
	import awm_pkg::*;

	generate
		if (TICK_CYC < 2) begin : g_bad
			$error("awm_top: TICK_CYC must be at least 2");
		end
	endgenerate

	function automatic logic signed [9:0] sx(input logic [7:0] v);
		sx = {{2{v[7]}}, v};
	endfunction

	logic [7:0]            upper_r [AWM_NCH];
	logic [7:0]            lower_r [AWM_NCH];
	logic [7:0]            hyst_r  [AWM_NCH];
	logic [8:0]            subst_r [AWM_NCH];
	logic [7:0]            fsel_r  [AWM_NTERM];
	logic [AWM_DW-1:0]     on_r    [AWM_NTERM];
	logic [AWM_DW-1:0]     off_r   [AWM_NTERM];
	logic [AWM_NCH-1:0]    flag_r;
	logic [AWM_NCH-1:0]    flag_nxt;
	logic [AWM_NTERM-1:0]  src;
	logic [AWM_NTERM-1:0]  term_r;
	logic [AWM_IRQ_W-1:0]  istat_r;
	logic [AWM_IRQ_W-1:0]  imask_r;
	logic                  ack_r;
	logic [31:0]           dat_r;
	logic [31:0]           rdata;
	logic                  req;
	logic                  wr;
	logic                  rd_stat;
	logic                  accept;
	logic                  reject;
	logic [1:0]            a_ch;
	logic [1:0]            a_reg;
	logic [2:0]            a_term;
	logic [2:0]            a_bank;
	logic signed [9:0]     w;
	logic signed [9:0]     floor_v;
	logic signed [9:0]     up_s;
	logic signed [9:0]     lo_s;
	logic signed [9:0]     hy_s;
	logic [31:0]           tick_cnt_r;
	logic                  tick;

	// bus decode
	assign req     = wb_cyc_i & wb_stb_i;
	assign wr      = req & wb_we_i & ack_r;
	assign rd_stat = req & ~wb_we_i & ack_r & (wb_adr_i == AWM_A_ISTAT);
	assign a_ch    = wb_adr_i[5:4];
	assign a_reg   = wb_adr_i[3:2];
	assign a_term  = wb_adr_i[4:2];
	assign a_bank  = wb_adr_i[7:5];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// write acceptance: a value out of range is refused and flagged
	always_comb begin
		w       = sx(wb_dat_i[7:0]);
		floor_v = (a_ch == 2'(AWM_CH_BIP)) ? AWM_PCT_MIN : 10'sd0;
		up_s    = sx(upper_r[a_ch == 2'h3 ? 2'h0 : a_ch]);
		lo_s    = sx(lower_r[a_ch == 2'h3 ? 2'h0 : a_ch]);
		hy_s    = sx(hyst_r[a_ch == 2'h3 ? 2'h0 : a_ch]);
		accept  = 1'b1;
		if (wb_adr_i < AWM_A_FLAGS) begin
			if (a_ch == 2'h3) begin
				accept = 1'b0;
			end else begin
				unique case (a_reg)
					AWM_R_UPPER: accept = (w >= lo_s + 2 * hy_s) && (w >= floor_v)
						&& (w <= AWM_PCT_MAX);
					AWM_R_LOWER: accept = (w <= up_s - 2 * hy_s) && (w >= floor_v)
						&& (w <= AWM_PCT_MAX);
					AWM_R_HYST:  accept = (w >= 10'sd0) && (w <= AWM_HYST_MAX)
						&& (2 * w <= up_s - lo_s);
					AWM_R_SUBST: accept = wb_dat_i[AWM_SUBST_IGN]
						|| ((w >= floor_v) && (w <= AWM_PCT_MAX));
				endcase
			end
		end else if (a_bank == AWM_B_ON || a_bank == AWM_B_OFF) begin
			accept = (wb_dat_i[AWM_DW-1:0] <= AWM_DLY_MAX)
				&& (wb_dat_i[31:AWM_DW] == '0);
		end
		if (!wb_sel_i[0] || !wb_sel_i[1]) begin
			accept = 1'b0;
		end
	end

	assign reject = wr && !accept;

	// configuration store, one block per concern
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int c = 0; c < AWM_NCH; c++) begin
				upper_r[c] <= AWM_RST_UPPER;
				lower_r[c] <= (c == AWM_CH_BIP) ? AWM_RST_LOWBP : AWM_RST_LOWER;
				hyst_r[c]  <= AWM_RST_HYST;
				subst_r[c] <= AWM_RST_SUBST;
			end
		end else if (wr && accept && wb_adr_i < AWM_A_FLAGS) begin
			unique case (a_reg)
				AWM_R_UPPER: upper_r[a_ch] <= wb_dat_i[7:0];
				AWM_R_LOWER: lower_r[a_ch] <= wb_dat_i[7:0];
				AWM_R_HYST:  hyst_r[a_ch]  <= wb_dat_i[7:0];
				AWM_R_SUBST: subst_r[a_ch] <= wb_dat_i[8:0];
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int t = 0; t < AWM_NTERM; t++) begin
				fsel_r[t] <= AWM_RST_FSEL;
				on_r[t]   <= '0;
				off_r[t]  <= '0;
			end
		end else if (wr && accept && a_term < 3'(AWM_NTERM)) begin
			if (a_bank == AWM_B_FSEL) begin
				fsel_r[a_term] <= wb_dat_i[7:0];
			end
			if (a_bank == AWM_B_ON) begin
				on_r[a_term] <= wb_dat_i[AWM_DW-1:0];
			end
			if (a_bank == AWM_B_OFF) begin
				off_r[a_term] <= wb_dat_i[AWM_DW-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			imask_r <= '0;
		end else if (wr && wb_adr_i == AWM_A_IMASK) begin
			imask_r <= wb_dat_i[AWM_IRQ_W-1:0];
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (wb_adr_i < AWM_A_FLAGS && a_ch != 2'h3) begin
			unique case (a_reg)
				AWM_R_UPPER: rdata = {24'h0, upper_r[a_ch]};
				AWM_R_LOWER: rdata = {24'h0, lower_r[a_ch]};
				AWM_R_HYST:  rdata = {24'h0, hyst_r[a_ch]};
				AWM_R_SUBST: rdata = {23'h0, subst_r[a_ch]};
			endcase
		end else if (wb_adr_i == AWM_A_FLAGS) begin
			rdata = {18'h0, term_r, 5'h0, flag_r};
		end else if (wb_adr_i == AWM_A_ISTAT) begin
			rdata = {28'h0, istat_r};
		end else if (wb_adr_i == AWM_A_IMASK) begin
			rdata = {28'h0, imask_r};
		end else if (a_term < 3'(AWM_NTERM)) begin
			if (a_bank == AWM_B_FSEL) begin
				rdata = {24'h0, fsel_r[a_term]};
			end else if (a_bank == AWM_B_ON) begin
				rdata = {21'h0, on_r[a_term]};
			end else if (a_bank == AWM_B_OFF) begin
				rdata = {21'h0, off_r[a_term]};
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req && !ack_r) begin
			dat_r <= rdata;
		end
	end

	// window comparators with hysteresis
	always_comb begin
		for (int c = 0; c < AWM_NCH; c++) begin
			if (flag_r[c]) begin
				flag_nxt[c] = !((sx(chan_data_i[c]) > sx(upper_r[c]) + sx(hyst_r[c]))
					|| (sx(chan_data_i[c]) < sx(lower_r[c]) - sx(hyst_r[c])));
			end else begin
				flag_nxt[c] = (sx(chan_data_i[c]) >= sx(lower_r[c]))
					&& (sx(chan_data_i[c]) <= sx(upper_r[c]));
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_r <= '0;
			for (int c = 0; c < AWM_NCH; c++) begin
				chan_data_o[c] <= '0;
			end
		end else begin
			flag_r <= flag_nxt;
			for (int c = 0; c < AWM_NCH; c++) begin
				// substitution follows the same edge as the flag
				chan_data_o[c] <= (flag_nxt[c] && !subst_r[c][AWM_SUBST_IGN]) ?
					subst_r[c][7:0] : chan_data_i[c];
			end
		end
	end

	assign window_flag_o = flag_r;
	assign disconnect_o  = flag_r;

	// 0.1 s time base shared by every terminal
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_r <= '0;
		end else if (tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end
	assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

	// terminal source routing and delay
	for (genvar t = 0; t < AWM_NTERM; t++) begin : g_term
		logic [AWM_DW-1:0] cnt_r;
		logic [AWM_DW-1:0] dly;
		always_comb begin
			unique case (fsel_r[t])
				AWM_F_DISC0, AWM_F_WIN0: src[t] = flag_r[0];
				AWM_F_DISC1, AWM_F_WIN1: src[t] = flag_r[1];
				AWM_F_DISC2, AWM_F_WIN2: src[t] = flag_r[2];
				default:                 src[t] = 1'b0;
			endcase
		end
		assign dly = src[t] ? on_r[t] : off_r[t];
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				term_r[t] <= 1'b0;
				cnt_r     <= '0;
			end else if (src[t] == term_r[t]) begin
				// a short glitch restarts the wait from zero
				cnt_r <= '0;
			end else if (dly == '0) begin
				term_r[t] <= src[t];
				cnt_r     <= '0;
			end else if (tick) begin
				if (cnt_r + 11'h1 >= dly) begin
					term_r[t] <= src[t];
					cnt_r     <= '0;
				end else begin
					cnt_r <= cnt_r + 11'h1;
				end
			end
		end
	end
	assign term_o = term_r;

	// sticky events; an event in the clearing read's cycle survives
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			istat_r <= '0;
		end else begin
			istat_r <= (rd_stat ? '0 : istat_r) | {reject, flag_nxt & ~flag_r};
		end
	end
	assign irq_o = |(istat_r & imask_r);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	win_enter_a: assert property (
		(sx(chan_data_i[0]) >= sx(lower_r[0]) && sx(chan_data_i[0]) <= sx(upper_r[0]))
		|=> disconnect_o[0])
		else $error("flag not set inside window");
	hyst_hold_a: assert property (
		flag_r[1] && sx(chan_data_i[1]) <= sx(upper_r[1]) + sx(hyst_r[1])
		&& sx(chan_data_i[1]) >= sx(lower_r[1]) - sx(hyst_r[1]) |=> flag_r[1])
		else $error("flag dropped inside hysteresis band");
	subst_use_a: assert property (
		flag_nxt[2] && !subst_r[2][AWM_SUBST_IGN] |=> chan_data_o[2] == $past(subst_r[2][7:0]))
		else $error("substitute level not applied");
	pass_thru_a: assert property (
		subst_r[0][AWM_SUBST_IGN] |=> chan_data_o[0] == $past(chan_data_i[0]))
		else $error("ignored substitute altered data");
	disc_equal_a: assert property (
		disconnect_o == window_flag_o)
		else $error("disconnect differs from window flag");
	route_now_a: assert property (
		fsel_r[1] == AWM_F_DISC1 && on_r[1] == '0 && off_r[1] == '0
		|=> term_o[1] == $past(flag_r[1]))
		else $error("zero-delay terminal lagged its source");
	upper_range_a: assert property (
		wr && wb_adr_i == 8'h00 && wb_dat_i[7:0] == 8'h65 |=> $stable(upper_r[0]))
		else $error("upper limit above 100 accepted");
	hyst_cap_a: assert property (
		sx(hyst_r[1]) <= AWM_HYST_MAX && 2 * sx(hyst_r[1]) <= sx(upper_r[1]) - sx(lower_r[1]))
		else $error("hysteresis out of range");
	delay_gate_a: assert property (
		!$stable(term_o[3]) |-> $past(src[3] != term_r[3]
		&& (g_term[3].dly == '0 || (tick && g_term[3].cnt_r + 11'h1 >= g_term[3].dly))))
		else $error("terminal switched before its delay");
	irq_level_a: assert property (
		rd_stat && !reject && (flag_nxt & ~flag_r) == '0
		|=> istat_r == '0 && !irq_o)
		else $error("interrupt status wrong");

	flag_rise_c: cover property ($rose(flag_r[2]));
	subst_c: cover property (flag_r[0] && !subst_r[0][AWM_SUBST_IGN]);
	delayed_on_c: cover property ($rose(term_o[0]) && on_r[0] != '0);
	reject_c: cover property (reject);
endmodule
`default_nettype wire

// >>> verif/awm_indicator_model.sv
// awm_indicator_model: lamp panel on the six terminals, counts switch-ons
`timescale 1ns/1ps
`default_nettype none
module awm_indicator_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// terminal levels
	input  wire logic [5:0] term_i,
	// switch-on count per lamp
	output logic [5:0][7:0] on_cnt_o
);
	logic [5:0] last_r;
	// edges, not levels: a held terminal is one event, a glitch shows up
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_r   <= '0;
			on_cnt_o <= '0;
		end else begin
			last_r <= term_i;
			for (int t = 0; t < 6; t++) begin
				if (term_i[t] && !last_r[t]) begin
					on_cnt_o[t] <= on_cnt_o[t] + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: self-checking bench for the window monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
	import awm_pkg::*;
	// short tick so delays fit the run
	localparam int  TK = 20;
	// config rows: addr, data
	localparam logic [19:0] CFG [18] = '{20'h00_03C, 20'h04_014, 20'h08_005, 20'h0C_032,
		20'h10_032, 20'h14_00A, 20'h20_00A, 20'h24_0D8, 20'h28_004, 20'h2C_0F6,
		20'h38_009, 20'h40_01B, 20'h44_01C, 20'h48_01D, 20'h4C_036, 20'h50_037,
		20'h54_038, 20'h5C_000};
	// rows: channel, sample, flag, data out
	localparam logic [23:0] ROWS [12] = '{24'h0_0A_0_0A, 24'h0_14_1_32, 24'h0_3E_1_32,
		24'h0_42_0_42, 24'h0_3C_1_32, 24'h0_0E_0_0E, 24'h1_09_0_09, 24'h1_1E_1_1E,
		24'h2_CE_0_CE, 24'h2_D8_1_F6, 24'h2_0E_1_F6, 24'h2_0F_0_0F};
	// refused or boundary writes: addr, data, readback
	localparam logic [31:0] BAD [10] = '{32'h00_065_03C, 32'h00_01D_03C, 32'h04_0FF_014,
		32'h04_033_014, 32'h08_00B_005, 32'h0C_065_032, 32'h0C_0FF_032, 32'h2C_09C_09C,
		32'h60_3E9_003, 32'h64_3E8_3E8};
	logic             clk_i;
	logic             resetn_i;
	logic             wb_cyc;
	logic             wb_stb;
	logic             wb_we;
	logic [7:0]       wb_adr;
	logic [3:0]       wb_sel;
	logic [31:0]      wb_wdat;
	logic [31:0]      wb_rdat;
	logic             wb_ack;
	logic [7:0]       din [AWM_NCH];
	logic [7:0]       dout [AWM_NCH];
	logic [2:0]       flg;
	logic [2:0]       disc;
	logic [5:0]       term;
	logic             irq;
	logic [5:0][7:0]  lamp_cnt;
	logic [31:0]      rd;
	logic [7:0]       c0;
	logic [3:0]       sel_v;
	int               miscompares;
	int               samples_checked;
	int               c;
	int               n;

	awm_top #(.TICK_CYC(TK)) i_awm_top (.clk_i(clk_i), .resetn_i(resetn_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.chan_data_i(din), .chan_data_o(dout), .window_flag_o(flg),
		.disconnect_o(disc), .term_o(term), .irq_o(irq));
	awm_indicator_model i_awm_indicator_model (.clk_i(clk_i), .resetn_i(resetn_i),
		.term_i(term), .on_cnt_o(lamp_cnt));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_wdat <= d;
		wb_sel  <= sel_v;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack !== 1'b1 && k < 50);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (k >= 50) begin
			miscompares++;
			give_verdict();
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	task automatic drv(input int ch, input logic [7:0] v);
		@(posedge clk_i);
		din[ch] <= v;
	endtask

	task automatic meas(input logic lvl, output int k);
		k = 0;
		while (term[0] !== lvl && k < 200) begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask

	initial begin
		resetn_i = 1'b0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
		din = '{8'h00, 8'h00, 8'h00};
		sel_v = 4'hF;
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		wb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h64)
		wb(1'b0, 8'h24, 32'h0);
		`CHK(rd, 32'h9C)
		wb(1'b0, 8'h0C, 32'h0);
		`CHK(rd, 32'h100)
		wb(1'b0, 8'hFC, 32'h0);
		`CHK(rd, 32'h0)
		foreach (CFG[i]) wb(1'b1, CFG[i][19:12], {20'h0, CFG[i][11:0]});
		foreach (ROWS[i]) begin
			c = int'(ROWS[i][23:20]);
			drv(c, ROWS[i][19:12]);
			wt(3);
			`CHK(flg[c], ROWS[i][8])
			`CHK(disc[c], ROWS[i][8])
			`CHK(dout[c], ROWS[i][7:0])
		end
		`CHK(term, 6'h12)
		wb(1'b0, AWM_A_FLAGS, 32'h0);
		`CHK(rd, 32'h1202)
		drv(1, 8'h09);
		wt(3);
		`CHK(term, 6'h00)
		// terminal 0 delayed, terminal 3 on the same flag stays immediate
		wb(1'b1, 8'h60, 32'h3);
		wb(1'b1, 8'h80, 32'h2);
		c0 = lamp_cnt[0];
		drv(0, 8'h1E);
		wt(25);
		drv(0, 8'h0E);
		wt(80);
		`CHK(lamp_cnt[0], c0)
		drv(0, 8'h1E);
		wt(3);
		`CHK(term[3], 1'b1)
		meas(1'b1, n);
		`CHK((n + 3 >= 38) && (n + 3 <= 66), 1'b1)
		drv(0, 8'h0E);
		meas(1'b0, n);
		`CHK((n >= 18) && (n <= 46), 1'b1)
		`CHK(lamp_cnt[0], c0 + 8'h01)
		// interrupt: masked, unmasked, read clear
		wb(1'b0, AWM_A_ISTAT, 32'h0);
		wt(0);
		`CHK(irq, 1'b0)
		drv(1, 8'h1E);
		wt(3);
		`CHK(irq, 1'b0)
		drv(0, 8'h1E);
		wt(3);
		`CHK(irq, 1'b1)
		wb(1'b0, AWM_A_ISTAT, 32'h0);
		`CHK(rd, 32'h3)
		wt(0);
		`CHK(irq, 1'b0)
		wb(1'b0, AWM_A_ISTAT, 32'h0);
		`CHK(rd, 32'h0)
		foreach (BAD[i]) begin
			wb(1'b1, BAD[i][31:24], {20'h0, BAD[i][23:12]});
			wb(1'b0, BAD[i][31:24], 32'h0);
			`CHK(rd, {20'h0, BAD[i][11:0]})
		end
		// lane 1 missing, lane 0 present: acked but refused
		sel_v = 4'h1;
		wb(1'b1, 8'h00, 32'h3D);
		sel_v = 4'hF;
		wb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h3C)
		`CHK(irq, 1'b1)
		wb(1'b0, AWM_A_ISTAT, 32'h0);
		`CHK(rd, 32'h8)
		// second reset in mid-run
		@(posedge clk_i);
		resetn_i <= 1'b0;
		wt(1);
		`CHK({flg, disc, term, irq, wb_ack}, 14'h0)
		@(posedge clk_i);
		resetn_i <= 1'b1;
		wb(1'b0, 8'h00, 32'h0);
		`CHK(rd, 32'h64)
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		give_verdict();
	end
endmodule
`default_nettype wire
